// file: char_link_pkg.sv
// Shared constants and types for the character link register block
package char_link_pkg;
    // Data path geometry
    localparam int CHAR_W      = 8;
    localparam int WORD_W      = 32;
    localparam int COUNT_W     = 16;
    localparam int FIFO_DEPTH  = 64;
    localparam int LEVEL_W     = 7;
    localparam int SKID_DEPTH  = 2;
    localparam int SKID_LEVEL_W = 2;

    // Word offsets of the two registers
    localparam logic [0:0] ADDR_DATA = 1'h0;
    localparam logic [0:0] ADDR_CTRL = 1'h1;

    // Field positions
    localparam int DATA_LO   = 0;
    localparam int VALID_BIT = 15;
    localparam int COUNT_LO  = 16;
    localparam int RX_IE_BIT = 0;
    localparam int TX_IE_BIT = 1;
    localparam int RX_IP_BIT = 8;
    localparam int TX_IP_BIT = 9;
    localparam int ACT_BIT   = 10;

    // Default interrupt thresholds, fixed at build time
    localparam logic [LEVEL_W-1:0] RX_THRESHOLD_DEF = 7'h08;
    localparam logic [LEVEL_W-1:0] TX_THRESHOLD_DEF = 7'h08;

    // Link frame: one flag bit then one character, LSB first
    localparam int         FRAME_W    = 9;
    localparam logic [3:0] FRAME_BITS = 4'h9;

    // Link framing states
    typedef enum logic [0:0] {
        LINK_IDLE  = 1'b0,
        LINK_FRAME = 1'b1
    } link_state_e;
endpackage : char_link_pkg

// file: fifo_if.sv
// Push and pop signals shared between a FIFO and its user
`timescale 1ns/1ns
`default_nettype none
interface fifo_if #(
    parameter int WIDTH   = 8,
    parameter int LEVEL_W = 7
);
    logic               push;
    logic [WIDTH-1:0]   wr_data;
    logic               full;
    logic               pop;
    logic [WIDTH-1:0]   rd_data;
    logic               rd_valid;
    logic [LEVEL_W-1:0] level;

    modport store (input push, input wr_data, input pop,
                   output full, output rd_data, output rd_valid, output level);
    modport user  (output push, output wr_data, output pop,
                   input full, input rd_data, input rd_valid, input level);
endinterface : fifo_if
`default_nettype wire

// file: char_fifo.sv
// Synchronous show-ahead FIFO with registered head word
`timescale 1ns/1ns
`default_nettype none
module char_fifo #(
    parameter int DEPTH   = 64,
    parameter int WIDTH   = 8,
    parameter int LEVEL_W = 7
) (
    input  wire logic core_clk,
    input  wire logic reset,
    fifo_if.store     port
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0]   mem [DEPTH];
    logic [PTR_W-1:0]   wr_ptr_r;
    logic [PTR_W-1:0]   rd_ptr_r;
    logic [PTR_W-1:0]   rd_ptr_nxt;
    logic [LEVEL_W-1:0] level_r;
    logic [LEVEL_W-1:0] level_nxt;
    logic [WIDTH-1:0]   head_r;
    logic               do_push;
    logic               do_pop;
    logic               bypass;

    // Push into a full FIFO and pop from an empty one are ignored
    assign do_push    = port.push && !port.full;
    assign do_pop     = port.pop && port.rd_valid;
    assign rd_ptr_nxt = do_pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    assign level_nxt  = level_r + LEVEL_W'(do_push) - LEVEL_W'(do_pop);
    // Writing the slot that becomes head: take the word straight in
    assign bypass     = do_push && (wr_ptr_r == rd_ptr_nxt);

    assign port.full     = (level_r == LEVEL_W'(DEPTH));
    assign port.rd_valid = (level_r != '0);
    assign port.rd_data  = head_r;
    assign port.level    = level_r;

    // Storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= port.wr_data;
        end
    end

    // Pointers, level and head register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
            head_r   <= '0;
        end else begin
            wr_ptr_r <= do_push ? wr_ptr_r + 1'b1 : wr_ptr_r;
            rd_ptr_r <= rd_ptr_nxt;
            level_r  <= level_nxt;
            head_r   <= bypass ? port.wr_data : mem[rd_ptr_nxt];
        end
    end
endmodule : char_fifo
`default_nettype wire

// file: char_link_regs.sv
// Register, interrupt and link logic of the scan-cable character port
// Behaviour
// - Two 32-bit registers: data at word offset 0, control at offset 1.
// - Data bits 7:0 hold a character; write pushes transmit, read pops receive.
// - Data bit 15 reads 1 when the returned character is valid.
// - Data upper field reads receive characters left after this read.
// - Read pops oldest receive character if any, else leaves FIFO and reads invalid.
// - Data write while transmit FIFO is full is silently dropped.
// - Control bit 0 is receive interrupt enable, bit 1 transmit enable.
// - Control bits 8 and 9 read receive and transmit pending, condition AND enable.
// - Control bit 10 sets on each host poll; cleared by writing 1.
// - Control upper field reads free entries in the transmit FIFO.
// - Reserved bits read as zero; software writes them as zero.
// - Single interrupt output is high when either condition is pending and enabled.
// - Transmit condition holds while transmit FIFO holds threshold or fewer characters.
// - Receive condition: free entries at most threshold, or characters with host idle.
// - Both thresholds are build-time parameters, default 8, not software writable.
// - Control write changes only enables, and clears activity where bit 10 is 1.
`timescale 1ns/1ns
`default_nettype none
module char_link_regs #(
    parameter logic [char_link_pkg::LEVEL_W-1:0] RX_THRESHOLD = char_link_pkg::RX_THRESHOLD_DEF,
    parameter logic [char_link_pkg::LEVEL_W-1:0] TX_THRESHOLD = char_link_pkg::TX_THRESHOLD_DEF
) (
    input  wire logic                               core_clk,
    input  wire logic                               reset,
    input  wire logic [0:0]                         reg_addr,
    input  wire logic                               reg_cs,
    input  wire logic                               reg_read,
    input  wire logic                               reg_write,
    input  wire logic [char_link_pkg::WORD_W-1:0]   reg_wdata,
    output logic      [char_link_pkg::WORD_W-1:0]   reg_rdata,
    output logic                                    irq,
    input  wire logic                               link_clk,
    input  wire logic                               link_frame,
    input  wire logic                               link_rx,
    output logic                                    link_tx
);
    localparam int CW = char_link_pkg::CHAR_W;
    localparam int LW = char_link_pkg::LEVEL_W;
    localparam int FW = char_link_pkg::FRAME_W;

    // FIFO ports
    fifo_if #(.WIDTH(CW), .LEVEL_W(LW)) tx_q ();
    fifo_if #(.WIDTH(CW), .LEVEL_W(LW)) rx_q ();
    fifo_if #(.WIDTH(CW), .LEVEL_W(char_link_pkg::SKID_LEVEL_W)) skid ();

    // Register bus decode
    logic                 data_sel;
    logic                 ctrl_sel;
    logic                 data_wr;
    logic                 data_rd;
    logic                 ctrl_wr;
    logic                 ctrl_rd;

    // Register state
    logic                 rx_ie_r;
    logic                 tx_ie_r;
    logic                 act_r;
    logic                 host_idle_r;
    logic [char_link_pkg::WORD_W-1:0] rdata_r;
    logic [char_link_pkg::WORD_W-1:0] rdata_nxt;

    // Status terms
    logic [LW-1:0]        tx_free;
    logic [LW-1:0]        rx_free;
    logic [LW-1:0]        rx_left;
    logic                 tx_cond;
    logic                 rx_cond;
    logic                 tx_ip;
    logic                 rx_ip;
    logic [char_link_pkg::WORD_W-1:0] data_word;
    logic [char_link_pkg::WORD_W-1:0] ctrl_word;
    logic                 act_set;
    logic                 act_clr;

    // Link synchronisers and framing
    logic                 lclk_s1_r;
    logic                 lclk_s2_r;
    logic                 lclk_s3_r;
    logic                 frm_s1_r;
    logic                 frm_s2_r;
    logic                 frm_s3_r;
    logic                 rx_s1_r;
    logic                 rx_s2_r;
    logic                 lclk_rise;
    logic                 lclk_fall;
    logic                 frame_start;
    logic                 frame_end;
    char_link_pkg::link_state_e state_r;
    char_link_pkg::link_state_e state_nxt;
    logic [3:0]           bit_cnt_r;
    logic [FW-1:0]        rx_shift_r;
    logic [FW-1:0]        tx_shift_r;
    logic [FW-1:0]        tx_load;
    logic                 tx_bit_r;
    logic                 frame_done;
    logic                 host_char;
    logic                 bit_take;

    // Character storage
    char_fifo #(.DEPTH(char_link_pkg::FIFO_DEPTH), .WIDTH(CW), .LEVEL_W(LW)) tx_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .port     (tx_q)
    );

    char_fifo #(.DEPTH(char_link_pkg::FIFO_DEPTH), .WIDTH(CW), .LEVEL_W(LW)) rx_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .port     (rx_q)
    );

    // Two-entry buffer between transmit FIFO and link, absorbs link stalls
    char_fifo #(
        .DEPTH   (char_link_pkg::SKID_DEPTH),
        .WIDTH   (CW),
        .LEVEL_W (char_link_pkg::SKID_LEVEL_W)
    ) tx_skid (
        .core_clk (core_clk),
        .reset    (reset),
        .port     (skid)
    );

    // Address decode; only one address bit, so no access is unmapped
    assign data_sel = reg_cs && (reg_addr == char_link_pkg::ADDR_DATA);
    assign ctrl_sel = reg_cs && (reg_addr == char_link_pkg::ADDR_CTRL);
    assign data_wr  = data_sel && reg_write;
    assign data_rd  = data_sel && reg_read;
    assign ctrl_wr  = ctrl_sel && reg_write;
    assign ctrl_rd  = ctrl_sel && reg_read;

    // Software side of the transmit FIFO; push into full FIFO is ignored
    assign tx_q.push    = data_wr;
    assign tx_q.wr_data = reg_wdata[char_link_pkg::DATA_LO +: CW];

    // Transmit FIFO feeds the buffer whenever the buffer has room
    assign skid.push    = tx_q.rd_valid && !skid.full;
    assign skid.wr_data = tx_q.rd_data;
    assign tx_q.pop     = tx_q.rd_valid && !skid.full;

    // Software side of the receive FIFO; pop only counts when a char is there
    assign rx_q.pop = data_rd;

    // Free space and characters left after the current read
    assign tx_free = LW'(char_link_pkg::FIFO_DEPTH) - tx_q.level;
    assign rx_free = LW'(char_link_pkg::FIFO_DEPTH) - rx_q.level;
    assign rx_left = rx_q.level - LW'(rx_q.rd_valid);

    // Interrupt conditions, thresholds fixed at build time
    assign tx_cond = (tx_q.level <= TX_THRESHOLD);
    assign rx_cond = (rx_free <= RX_THRESHOLD)
                   || (rx_q.rd_valid && host_idle_r);
    assign tx_ip   = tx_cond && tx_ie_r;
    assign rx_ip   = rx_cond && rx_ie_r;
    assign irq     = tx_ip || rx_ip;

    // Read words; reserved bits read as zero
    assign data_word = {char_link_pkg::COUNT_W'(rx_left),
                        rx_q.rd_valid,
                        7'h00,
                        rx_q.rd_data};
    assign ctrl_word = {char_link_pkg::COUNT_W'(tx_free),
                        5'h00,
                        act_r,
                        tx_ip,
                        rx_ip,
                        6'h00,
                        tx_ie_r,
                        rx_ie_r};

    // Read data held until the next read
    assign rdata_nxt = data_rd ? data_word
                     : ctrl_rd ? ctrl_word
                     : rdata_r;
    assign reg_rdata = rdata_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Interrupt enables; the other control fields are not writable
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_ie_r <= 1'b0;
            tx_ie_r <= 1'b0;
        end else if (ctrl_wr) begin
            rx_ie_r <= reg_wdata[char_link_pkg::RX_IE_BIT];
            tx_ie_r <= reg_wdata[char_link_pkg::TX_IE_BIT];
        end
    end

    // Activity flag: a poll in the clearing cycle wins, so none is lost
    assign act_set = frame_start;
    assign act_clr = ctrl_wr && reg_wdata[char_link_pkg::ACT_BIT];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            act_r <= 1'b0;
        end else if (act_set) begin
            act_r <= 1'b1;
        end else if (act_clr) begin
            act_r <= 1'b0;
        end
    end

    // Two-flop synchronisers for the link pins, plus a delay stage for edges
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lclk_s1_r <= 1'b0;
            lclk_s2_r <= 1'b0;
            lclk_s3_r <= 1'b0;
            frm_s1_r  <= 1'b0;
            frm_s2_r  <= 1'b0;
            frm_s3_r  <= 1'b0;
            rx_s1_r   <= 1'b0;
            rx_s2_r   <= 1'b0;
        end else begin
            lclk_s1_r <= link_clk;
            lclk_s2_r <= lclk_s1_r;
            lclk_s3_r <= lclk_s2_r;
            frm_s1_r  <= link_frame;
            frm_s2_r  <= frm_s1_r;
            frm_s3_r  <= frm_s2_r;
            rx_s1_r   <= link_rx;
            rx_s2_r   <= rx_s1_r;
        end
    end

    // Edges seen only after both sync stages
    assign lclk_rise   = lclk_s2_r && !lclk_s3_r;
    assign lclk_fall   = !lclk_s2_r && lclk_s3_r;
    assign frame_start = (state_r == char_link_pkg::LINK_IDLE) && frm_s2_r && !frm_s3_r;
    assign frame_end   = (state_r == char_link_pkg::LINK_FRAME) && !frm_s2_r && frm_s3_r;

    // Link state: a frame runs from frame rise to frame fall
    always_comb begin
        case (state_r)
            char_link_pkg::LINK_IDLE: begin
                state_nxt = frame_start ? char_link_pkg::LINK_FRAME : char_link_pkg::LINK_IDLE;
            end
            char_link_pkg::LINK_FRAME: begin
                state_nxt = frame_end ? char_link_pkg::LINK_IDLE : char_link_pkg::LINK_FRAME;
            end
            default: begin
                state_nxt = char_link_pkg::LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= char_link_pkg::LINK_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outgoing frame: flag bit then character; flag 0 when nothing to send.
    // The character leaves the buffer at frame start, so a cut frame loses it.
    assign tx_load  = skid.rd_valid ? {skid.rd_data, 1'b1} : '0;
    assign skid.pop = frame_start;
    assign bit_take = (state_r == char_link_pkg::LINK_FRAME) && lclk_rise
                    && (bit_cnt_r != char_link_pkg::FRAME_BITS);

    // Bit counter and incoming shift register, host samples on rising edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bit_cnt_r  <= '0;
            rx_shift_r <= '0;
        end else if (frame_start) begin
            bit_cnt_r  <= '0;
        end else if (bit_take) begin
            bit_cnt_r  <= bit_cnt_r + 4'h1;
            rx_shift_r <= {rx_s2_r, rx_shift_r[FW-1:1]};
        end
    end

    // Outgoing shift register, changes on falling edge so host sees it settled
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_shift_r <= '0;
            tx_bit_r   <= 1'b0;
        end else if (frame_start) begin
            tx_shift_r <= tx_load;
            tx_bit_r   <= tx_load[0];
        end else if ((state_r == char_link_pkg::LINK_FRAME) && lclk_fall) begin
            tx_shift_r <= {1'b0, tx_shift_r[FW-1:1]};
            tx_bit_r   <= tx_shift_r[1];
        end else if (state_r == char_link_pkg::LINK_IDLE) begin
            tx_bit_r   <= 1'b0;
        end
    end
    assign link_tx = tx_bit_r;

    // Complete frames only; a short frame is discarded
    assign frame_done   = frame_end && (bit_cnt_r == char_link_pkg::FRAME_BITS);
    assign host_char    = frame_done && rx_shift_r[0];
    assign rx_q.push    = host_char;
    assign rx_q.wr_data = rx_shift_r[FW-1:1];

    // Host idle: set by a frame without a character, cleared by one with
    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_idle_r <= 1'b0;
        end else if (frame_done) begin
            host_idle_r <= !rx_shift_r[0];
        end
    end
endmodule : char_link_regs
`default_nettype wire

// file: char_link_regs_assertions.sv
// Checker for register port and link timing of the character link block
`timescale 1ns/1ns
`default_nettype none
module char_link_regs_assertions #(
    parameter logic [6:0] RX_THRESHOLD = 7'h08,
    parameter logic [6:0] TX_THRESHOLD = 7'h08
) (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [0:0]  reg_addr,
    input wire logic        reg_cs,
    input wire logic        reg_read,
    input wire logic        reg_write,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq,
    input wire logic        link_clk,
    input wire logic        link_frame,
    input wire logic        link_rx,
    input wire logic        link_tx
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Access decode
    wire data_rd = reg_cs && reg_read && !reg_addr[0];
    wire ctrl_rd = reg_cs && reg_read && reg_addr[0];
    wire ctrl_wr = reg_cs && reg_write && reg_addr[0];

    property p_rdata_stands;
        !(reg_cs && reg_read) |=> $stable(reg_rdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
    property p_empty_read;
        data_rd |=> reg_rdata[15] || (reg_rdata[31:16] == 16'h0);
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("invalid read with count");
    property p_pend_qual;
        ctrl_rd |=> (!reg_rdata[8] || reg_rdata[0]) && (!reg_rdata[9] || reg_rdata[1]);
    endproperty
    a_pend_qual: assert property (p_pend_qual) else $error("pending without enable");
    // Interrupt line and pending bits seen at the same edge
    property p_irq_mirror;
        ctrl_rd |=> (reg_rdata[8] || reg_rdata[9]) == $past(irq);
    endproperty
    a_irq_mirror: assert property (p_irq_mirror) else $error("irq differs from pending");
    property p_free_range;
        ctrl_rd |=> reg_rdata[31:16] <= 16'h0040;
    endproperty
    a_free_range: assert property (p_free_range) else $error("free count too large");
    property p_enable_back;
        ctrl_wr ##1 ctrl_rd |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2);
    endproperty
    a_enable_back: assert property (p_enable_back) else $error("enables not stored");
    // Quiet link before and during the access, so no new poll can set the flag
    property p_act_clear;
        (!link_frame)[*4] ##0 (ctrl_wr && reg_wdata[10]) ##1 (ctrl_rd && !link_frame)
            |=> !reg_rdata[10];
    endproperty
    a_act_clear: assert property (p_act_clear) else $error("activity not cleared");
    property p_irq_off;
        ctrl_wr && (reg_wdata[1:0] == 2'h0) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with enables off");
    property p_tx_idle;
        (!link_frame)[*8] |-> !link_tx;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("serial out busy when idle");

    // Main scenarios reached
    c_valid_read: cover property (data_rd ##1 reg_rdata[15]);
    c_irq_rise: cover property ($rose(irq));
    c_act_clear: cover property (ctrl_wr && reg_wdata[10]);
endmodule : char_link_regs_assertions

bind char_link_regs char_link_regs_assertions #(
    .RX_THRESHOLD(RX_THRESHOLD), .TX_THRESHOLD(TX_THRESHOLD)
) u_char_link_regs_assertions (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_cs(reg_cs),
    .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq(irq), .link_clk(link_clk), .link_frame(link_frame),
    .link_rx(link_rx), .link_tx(link_tx)
);
`default_nettype wire

// file: host_link_model.sv
// Host end of the serial link, trading one character each way per frame
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
    input  wire logic core_clk,
    input  wire logic link_tx,
    output logic      link_clk,
    output logic      link_frame,
    output logic      link_rx
);
    logic [8:0] got_r;

    // Link clock stands low between frames
    initial begin
        link_clk   = 1'b0;
        link_frame = 1'b0;
        link_rx    = 1'b1;
        got_r      = 9'h0;
    end

    // n bits LSB first, nine for a whole frame; 3 ns offset keeps link edges off core edges
    task automatic frame(input logic [8:0] bits, input int n);
        #3 link_frame = 1'b1;
        for (int i = 0; i < n; i++) begin
            link_rx = bits[i];
            #80 link_clk = 1'b1;
            got_r[i] = link_tx;
            #80 link_clk = 1'b0;
        end
        // Released line flips so a stale bit cannot pass for data
        link_rx = ~link_rx;
        #40 link_frame = 1'b0;
        #80 @(posedge core_clk);
    endtask : frame
endmodule : host_link_model
`default_nettype wire

// file: tb_char_link_regs.sv
// Self-checking bench for the character link register block
`timescale 1ns/1ns
`default_nettype none
module tb_char_link_regs;
    logic        core_clk;
    logic        reset;
    logic [0:0]  reg_addr;
    logic        reg_cs;
    logic        reg_read;
    logic        reg_write;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        irq;
    logic        link_clk;
    logic        link_frame;
    logic        link_rx;
    logic        link_tx;
    logic [31:0] q;
    int          err_count;
    int          cmp_count;

    char_link_regs u_char_link_regs (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_cs(reg_cs),
        .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .irq(irq), .link_clk(link_clk),
        .link_frame(link_frame), .link_rx(link_rx), .link_tx(link_tx)
    );
    host_link_model u_host_link_model (
        .core_clk(core_clk), .link_tx(link_tx), .link_clk(link_clk),
        .link_frame(link_frame), .link_rx(link_rx)
    );

    // 100 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // Strobe held edge to edge, so back-to-back accesses need no gap
    task automatic drive(input logic [0:0] a, input logic wr, input logic [31:0] d);
        reg_cs    <= 1'b1;
        reg_addr  <= a;
        reg_write <= wr;
        reg_read  <= ~wr;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask : drive

    task automatic idle(input int n);
        reg_cs    <= 1'b0;
        reg_write <= 1'b0;
        reg_read  <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic wr(input logic [0:0] a, input logic [31:0] d);
        drive(a, 1'b1, d);
        idle(1);
    endtask : wr

    // Read data stands after the taking edge, so it is picked up one edge later
    task automatic rd(input logic [0:0] a);
        drive(a, 1'b0, 32'h0);
        idle(1);
        q = reg_rdata;
    endtask : rd

    // Hang guard, well above the roughly 11000 cycles of the sequence
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        summarize();
    end

    // Main sequence
    initial begin
        reset     = 1'b1;
        reg_addr  = 1'h0;
        reg_cs    = 1'b0;
        reg_read  = 1'b0;
        reg_write = 1'b0;
        reg_wdata = 32'h0;
        err_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        idle(4);
        rd(1'h1);
        check("ctrl reset", q, 32'h0040_0000);
        rd(1'h0);
        check("empty read", q & 32'hffff_8000, 32'h0);
        // Ten writes: two sit in the link buffer, eight in the FIFO
        for (int i = 0; i < 10; i++) wr(1'h0, 32'h41 + i);
        idle(4);
        drive(1'h1, 1'b1, 32'h2);
        rd(1'h1);
        check("tx at threshold", q, 32'h0038_0202);
        check("irq tx", {31'h0, irq}, 32'h1);
        wr(1'h0, 32'h4b);
        rd(1'h1);
        check("tx above threshold", q, 32'h0037_0002);
        // Overfill: the last four characters are dropped
        for (int i = 11; i < 70; i++) wr(1'h0, 32'h41 + i);
        idle(4);
        rd(1'h1);
        check("tx full", q, 32'h0000_0002);
        wr(1'h1, 32'h1);
        // Each frame drains one character and brings one in
        for (int i = 0; i < 66; i++) begin
            u_host_link_model.frame({8'(8'h20 + i), 1'b1}, 9);
            check("to host", {23'h0, u_host_link_model.got_r}, {23'h0, 8'(8'h41 + i), 1'b1});
            rd(1'h1);
            check("drain ctrl", q, {(i > 62) ? 16'h0040 : 16'(i + 1), 7'h2, i > 54, 8'h01});
        end
        u_host_link_model.frame(9'h0fe, 9);
        check("idle to host", {31'h0, u_host_link_model.got_r[0]}, 32'h0);
        // Cut frame must be discarded; taking it would end host idle before the drain
        u_host_link_model.frame(9'h1ff, 5);
        drive(1'h1, 1'b1, 32'h401);
        rd(1'h1);
        check("act clear", q, 32'h0040_0101);
        check("irq rx", {31'h0, irq}, 32'h1);
        for (int i = 0; i < 64; i++) begin
            rd(1'h0);
            check("rx char", q, {16'(63 - i), 1'b1, 7'h0, 8'(8'h20 + i)});
            if (i == 60) check("irq idle host", {31'h0, irq}, 32'h1);
        end
        check("irq drained", {31'h0, irq}, 32'h0);
        rd(1'h0);
        check("empty again", q & 32'hffff_8000, 32'h0);
        wr(1'h1, 32'h0);
        summarize();
    end
endmodule : tb_char_link_regs
`default_nettype wire
